// File: rtl/padp_port.sv
// padp_port: pci address/data, command/byte-enable and parity port
// assumes arbitration and target decode live outside and report
// through gntOk and tgtSel; the wire levels are resolved outside
`timescale 1ns/1ps
module padp_port
   import padp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire padp_req_t mstReq, // request to start as master
   input wire logic mstReqValid, // request pending, level
   input wire logic gntOk, // arbiter grant, level
   input wire padp_word_t mstWr, // next write word
   output padp_word_t mstRd, // read word from the target
   output logic mstRdValid, // read word pulse
   output logic mstWrTake, // write word consumed pulse
   output logic mstDone, // last data phase done pulse
   output logic mstBusy, // master engine active
   input wire logic tgtSel, // we were claimed as target
   input wire logic tgtWrite, // claimed access is a write
   input wire logic [AD_W-1:0] tgtRdData, // read data to return
   input wire logic tgtRdy, // read data or write space ready
   output logic tgtTake, // read word consumed pulse
   output padp_word_t tgtWr, // write word from the master
   output logic tgtWrValid, // write word pulse
   output logic parBad, // received data parity mismatch pulse
   input wire logic [AD_W-1:0] adIn,
   output logic [AD_W-1:0] adOut,
   output logic adOe,
   input wire logic [CBE_W-1:0] cbeIn_n,
   output logic [CBE_W-1:0] cbeOut_n,
   output logic cbeOe,
   input wire logic parIn,
   output logic parOut,
   output logic parOe,
   input wire logic frameIn_n,
   output logic frameOut_n,
   output logic frameOe,
   input wire logic irdyIn_n,
   output logic irdyOut_n,
   output logic irdyOe,
   input wire logic trdyIn_n,
   output logic trdyOut_n,
   output logic trdyOe
);

   ////////////////////////////////////////////////////////////////////
   // state and pin registers
   padp_drv_t drv_reg; // everything driven on the bus
   padp_drv_t drv_next;
   padp_mst_t mSt_reg; // master engine
   padp_mst_t mSt_next;
   padp_tgt_t tSt_reg; // target engine
   padp_tgt_t tSt_next;
   logic [LEN_W-1:0] cnt_reg; // data phases left
   logic [LEN_W-1:0] cnt_next;
   logic mWr_reg; // master access is a write
   logic tWr_reg; // target access is a write
   logic idlePrev_reg; // frame and irdy were high last cycle
   logic chk_reg; // a received word waits for its parity
   logic expPar_reg; // parity expected for that word
   logic done; // data phase completes this edge
   logic busIdle; // frame and irdy free long enough
   logic mStart; // master engine takes the bus

   assign done = !irdyIn_n && !trdyIn_n;
   // released for a full cycle before we assert anything
   assign busIdle = frameIn_n && irdyIn_n && idlePrev_reg;
   // target claim wins so both engines never drive at once
   assign mStart = mstReqValid && gntOk && busIdle && !tgtSel &&
                   tSt_reg == T_IDLE;

   ////////////////////////////////////////////////////////////////////
   // next values of the bus drivers and both engines
   always_comb begin
      drv_next = drv_reg;
      mSt_next = mSt_reg;
      tSt_next = tSt_reg;
      cnt_next = cnt_reg;
      case (mSt_reg)
         M_IDLE: begin
            if (mStart) begin
               // address phase: address and command, frame low
               drv_next.ad = padp_addr_phase(mstReq.cmd,
                                             mstReq.addr);
               drv_next.adOe = 1'b1;
               drv_next.cbe = mstReq.cmd;
               drv_next.cbeOe = 1'b1;
               drv_next.frame = 1'b0;
               drv_next.frameOe = 1'b1;
               cnt_next = (mstReq.len == LEN_ZERO) ? LEN_ONE :
                          mstReq.len;
               mSt_next = M_ADDR;
            end
         end
         M_ADDR: begin
            // address parity goes out one clock behind the address
            drv_next.par = padp_par(drv_reg.ad, drv_reg.cbe);
            drv_next.parOe = 1'b1;
            drv_next.cbe = ~mstWr.be;
            drv_next.irdy = 1'b0;
            drv_next.irdyOe = 1'b1;
            drv_next.frame = (cnt_reg == LEN_ONE);
            if (mWr_reg) begin
               drv_next.ad = mstWr.data;
            end else begin
               drv_next.adOe = 1'b0; // turnaround for the target
            end
            mSt_next = M_DATA;
         end
         M_DATA: begin
            if (mWr_reg) begin
               // tracks the driven word one clock late, so it holds
               // one clock past completion
               drv_next.par = padp_par(drv_reg.ad,
                                       drv_reg.cbe);
            end else begin
               drv_next.parOe = 1'b0; // target owns read parity
            end
            if (done && cnt_reg == LEN_ONE) begin
               drv_next.irdy = 1'b1; // high before floating
               drv_next.frameOe = 1'b0; // high through last phase
               drv_next.adOe = 1'b0;
               drv_next.cbeOe = 1'b0;
               mSt_next = M_TURN;
            end else if (done) begin
               cnt_next = cnt_reg - LEN_ONE;
               drv_next.frame = (cnt_reg == LEN_TWO);
               drv_next.cbe = ~mstWr.be;
               if (mWr_reg) begin
                  drv_next.ad = mstWr.data;
               end
            end
         end
         M_TURN: begin
            drv_next.irdyOe = 1'b0;
            drv_next.parOe = 1'b0;
            mSt_next = M_REL;
         end
         M_REL: begin
            mSt_next = M_IDLE; // one free cycle before reuse
         end
         default: begin
            mSt_next = M_IDLE;
         end
      endcase
      case (tSt_reg)
         T_IDLE: begin
            if (tgtSel && mSt_reg == M_IDLE) begin
               // take trdy driven high first, never low at once
               drv_next.trdy = 1'b1;
               drv_next.trdyOe = 1'b1;
               if (!tgtWrite) begin
                  drv_next.ad = tgtRdData;
                  drv_next.adOe = 1'b1;
               end
               tSt_next = T_DATA;
            end
         end
         T_DATA: begin
            drv_next.trdy = !tgtRdy;
            if (!tWr_reg) begin
               // byte enables come from the master's lines as seen
               drv_next.par = padp_par(drv_reg.ad,
                                       cbeIn_n);
               drv_next.parOe = 1'b1;
            end
            if (done && frameIn_n) begin
               drv_next.trdy = 1'b1;
               drv_next.adOe = 1'b0;
               tSt_next = T_TURN;
            end else if (done && !tWr_reg) begin
               drv_next.ad = tgtRdData;
            end
         end
         T_TURN: begin
            drv_next.trdyOe = 1'b0;
            drv_next.parOe = 1'b0;
            tSt_next = T_REL;
         end
         T_REL: begin
            tSt_next = T_IDLE;
         end
         default: begin
            tSt_next = T_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // bus driver registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         drv_reg <= DRV_RST;
      end else begin
         drv_reg <= drv_next;
      end
   end

   // pins come straight off the register, in struct field order
   assign {adOut, adOe, cbeOut_n, cbeOe, parOut, parOe, frameOut_n,
           frameOe, irdyOut_n, irdyOe, trdyOut_n, trdyOe} = drv_reg;

   ////////////////////////////////////////////////////////////////////
   // master engine state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mSt_reg <= M_IDLE;
         cnt_reg <= LEN_ZERO;
         mWr_reg <= 1'b0;
         idlePrev_reg <= 1'b0;
      end else begin
         mSt_reg <= mSt_next;
         cnt_reg <= cnt_next;
         idlePrev_reg <= frameIn_n && irdyIn_n;
         if (mStart) begin
            mWr_reg <= padp_is_write(mstReq.cmd);
         end
      end
   end

   // target engine state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tSt_reg <= T_IDLE;
         tWr_reg <= 1'b0;
      end else begin
         tSt_reg <= tSt_next;
         if (tSt_reg == T_IDLE) begin
            tWr_reg <= tgtWrite;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // user side strobes and words
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         {mstRd, mstRdValid, mstWrTake, mstDone, mstBusy, tgtTake, tgtWr,
          tgtWrValid} <= '0;
      end else begin
         mstBusy <= mSt_next != M_IDLE;
         mstRdValid <= mSt_reg == M_DATA && done && !mWr_reg;
         mstWrTake <= mWr_reg && ((mSt_reg == M_ADDR) ||
            (mSt_reg == M_DATA && done && cnt_reg != LEN_ONE));
         mstDone <= mSt_reg == M_DATA && done && cnt_reg == LEN_ONE;
         tgtTake <= tSt_reg == T_DATA && done && !tWr_reg;
         tgtWrValid <= tSt_reg == T_DATA && done && tWr_reg;
         if (mSt_reg == M_DATA && done) begin
            mstRd <= '{data: adIn, be: ~drv_reg.cbe};
         end
         if (tSt_reg == T_DATA && done) begin
            tgtWr <= '{data: adIn, be: ~cbeIn_n};
         end
      end
   end

   // received parity arrives one clock after the data phase ends
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         {chk_reg, expPar_reg, parBad} <= 3'h0;
      end else begin
         chk_reg <= done && ((mSt_reg == M_DATA && !mWr_reg) ||
                             (tSt_reg == T_DATA && tWr_reg));
         expPar_reg <= padp_par(adIn, cbeIn_n);
         parBad <= chk_reg && (parIn != expPar_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_single_owner: assert property (
      !(drv_reg.irdyOe && drv_reg.trdyOe) &&
      !(drv_reg.frameOe && tSt_reg != T_IDLE))
      else $error("both engines own control lines");
   a_irdy_high_float: assert property (
      $fell(drv_reg.irdyOe) |-> $past(drv_reg.irdy) &&
      $past(drv_reg.irdyOe))
      else $error("irdy floated without high cycle");
   a_trdy_high_float: assert property (
      $fell(drv_reg.trdyOe) |-> $past(drv_reg.trdy))
      else $error("trdy floated without high cycle");
   a_frame_take_gap: assert property (
      $rose(drv_reg.frameOe) |-> $past(frameIn_n) &&
      $past(irdyIn_n, 2) && drv_reg.irdy)
      else $error("frame taken too early");
   a_addr_phase_drive: assert property (
      mSt_reg == M_ADDR |-> drv_reg.adOe && drv_reg.cbeOe &&
      !drv_reg.frame && !drv_reg.irdyOe)
      else $error("address phase not driven");
   a_addr_parity_time: assert property (
      mSt_reg == M_ADDR |=> drv_reg.parOe &&
      drv_reg.par == ^{$past(drv_reg.ad), $past(drv_reg.cbe)})
      else $error("address parity wrong or late");
   a_write_parity_lag: assert property (
      mSt_reg == M_DATA && mWr_reg |=> drv_reg.parOe &&
      drv_reg.par == ^{$past(drv_reg.ad), $past(drv_reg.cbe)})
      else $error("write parity not one clock behind");
   a_read_parity_tgt: assert property (
      tSt_reg == T_DATA && !tWr_reg |=> drv_reg.parOe &&
      drv_reg.par == ^{$past(drv_reg.ad), $past(cbeIn_n)})
      else $error("target read parity wrong");
   a_read_release_ad: assert property (
      mSt_reg == M_DATA && !mWr_reg |-> !drv_reg.adOe &&
      drv_reg.cbeOe && !drv_reg.irdy)
      else $error("master drove ad on read");
   a_frame_last_phase: assert property (
      mSt_reg == M_DATA && cnt_reg == LEN_ONE |-> drv_reg.frame)
      else $error("frame low in final phase");
   a_phase_count_down: assert property (
      mSt_reg == M_DATA && done && cnt_reg != LEN_ONE |=>
      cnt_reg == $past(cnt_reg) - LEN_ONE && mSt_reg == M_DATA)
      else $error("completed phase not counted");

endmodule : padp_port

// File: rtl/padp_pkg.sv
// padp_pkg: types, constants and helpers of the pci address/data port
// assumes one clock domain, the pci clock, and no software registers
package padp_pkg;

   localparam int AD_W = 32; // multiplexed address/data width
   localparam int CBE_W = 4; // command / byte-enable width
   localparam int LEN_W = 4; // data phase count width

   localparam logic [LEN_W-1:0] LEN_ZERO = 4'h0; // count after reset
   localparam logic [LEN_W-1:0] LEN_ONE = 4'h1; // final data phase
   localparam logic [LEN_W-1:0] LEN_TWO = 4'h2; // phase before final
   localparam logic [AD_W-1:0] AD_RST = 32'h0; // address/data reset
   localparam logic [CBE_W-1:0] CBE_RST = 4'hf; // lanes off at reset
   localparam logic [2:0] IO_CMD_HI = 3'h1; // io commands are 001x
   localparam logic [1:0] DW_LOW = 2'h0; // low bits, dword address

   // master engine states
   typedef enum logic [2:0] {
      M_IDLE = 3'h0,
      M_ADDR = 3'h1,
      M_DATA = 3'h2,
      M_TURN = 3'h3,
      M_REL = 3'h4
   } padp_mst_t;

   // target engine states
   typedef enum logic [1:0] {
      T_IDLE = 2'h0,
      T_DATA = 2'h1,
      T_TURN = 2'h2,
      T_REL = 2'h3
   } padp_tgt_t;

   // master request: command, address, number of data phases
   typedef struct packed {
      logic [CBE_W-1:0] cmd;
      logic [AD_W-1:0] addr;
      logic [LEN_W-1:0] len;
   } padp_req_t;

   // one data word with active-high byte enables
   typedef struct packed {
      logic [AD_W-1:0] data;
      logic [CBE_W-1:0] be;
   } padp_word_t;

   // everything the port drives onto the bus, with enables
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic adOe;
      logic [CBE_W-1:0] cbe;
      logic cbeOe;
      logic par;
      logic parOe;
      logic frame;
      logic frameOe;
      logic irdy;
      logic irdyOe;
      logic trdy;
      logic trdyOe;
   } padp_drv_t;

   localparam padp_drv_t DRV_RST = '{ad: AD_RST, adOe: 1'b0,
      cbe: CBE_RST, cbeOe: 1'b0, par: 1'b0, parOe: 1'b0,
      frame: 1'b1, frameOe: 1'b0, irdy: 1'b1, irdyOe: 1'b0,
      trdy: 1'b1, trdyOe: 1'b0};

   // even parity bit over the 36 lines
   function automatic logic padp_par(input logic [AD_W-1:0] ad,
                                     input logic [CBE_W-1:0] cbe);
      return ^{ad, cbe};
   endfunction : padp_par

   // write commands have the low command bit set
   function automatic logic padp_is_write(input logic [CBE_W-1:0] cmd);
      return cmd[0];
   endfunction : padp_is_write

   // io keeps a byte address, others carry a dword address
   function automatic logic [AD_W-1:0] padp_addr_phase(
         input logic [CBE_W-1:0] cmd, input logic [AD_W-1:0] addr);
      if (cmd[3:1] == IO_CMD_HI) begin
         return addr;
      end
      return {addr[AD_W-1:2], DW_LOW};
   endfunction : padp_addr_phase

endpackage : padp_pkg

// File: sim/padp_peer.sv
// padp_peer: behavioural pci agent on the far side of the port
// assumes the bench resolves every wire and feeds the levels back
`timescale 1ns/1ps
module padp_peer
   import padp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic stall, // hold target ready off this cycle
   input wire logic [AD_W-1:0] adW,
   input wire logic [CBE_W-1:0] cbeW_n,
   input wire logic parW,
   input wire logic frameW_n,
   input wire logic irdyW_n,
   input wire logic trdyW_n,
   output padp_drv_t drv, // our drivers and enables
   output logic claim // decode claim towards the port
);
   logic [AD_W+CBE_W-1:0] addrQ[$]; // address phases we served
   padp_word_t capQ[$]; // words completed on the bus
   logic [AD_W-1:0] rdQ[$]; // data we return as target
   int parErr; // parity mismatches seen
   logic mBusy, fp, frPrev, parLast, oePrev, parChk;
   wire logic compl = !irdyW_n && !trdyW_n;

   initial begin
      drv = DRV_RST;
      {claim, mBusy, parLast, oePrev, parChk} = 5'h0;
      {fp, frPrev} = 2'h3;
      parErr = 0;
   end
   ////////////////////////////////////////////////////////////////
   // when the port drove ad in a phase it must show its parity next cycle
   always @(posedge clk) begin
      if (parChk && parW !== parLast) begin
         parErr++;
      end
      parChk <= (compl || (frPrev && !frameW_n)) && !drv.adOe;
      parLast <= ^{adW, cbeW_n};
      oePrev <= drv.adOe;
      frPrev <= frameW_n;
   end
   // our own parity trails our own ad by one clock, then floats
   always @(negedge clk) begin
      drv.par = parLast;
      drv.parOe = oePrev;
   end
   // answer as target when the port opens a transaction
   always @(posedge clk) begin
      if (reset_n && fp && !frameW_n && !mBusy) begin
         serve();
      end
      fp = frameW_n;
   end
   ////////////////////////////////////////////////////////////////
   // target side: ready high first, then random waits per phase
   task automatic serve();
      logic wr, last, need;
      wr = cbeW_n[0];
      addrQ.push_back({adW, cbeW_n});
      {last, need} = 2'h1;
      @(negedge clk);
      drv.trdy = 1'b1;
      drv.trdyOe = 1'b1;
      while (!last) begin
         @(negedge clk);
         if (need && !wr && !stall) begin
            drv.ad = rdQ.pop_front();
            drv.adOe = 1'b1;
         end
         need = need && stall;
         drv.trdy = stall;
         @(posedge clk);
         if (compl) begin
            capQ.push_back({adW, ~cbeW_n});
            last = frameW_n;
            need = 1'b1;
         end
      end
      @(negedge clk);
      drv.trdy = 1'b1;
      drv.adOe = 1'b0;
      @(negedge clk);
      drv.trdyOe = 1'b0;
   endtask : serve
   // master side: one address phase, then the given data phases
   task automatic run(input logic [CBE_W-1:0] cmd,
         input logic [AD_W-1:0] addr, input padp_word_t w[$]);
      mBusy = 1'b1;
      @(negedge clk);
      drv.frame = 1'b0;
      drv.ad = addr;
      drv.cbe = cmd;
      drv.irdy = 1'b1;
      {drv.frameOe, drv.adOe, drv.cbeOe, drv.irdyOe} = 4'hf;
      foreach (w[k]) begin
         @(negedge clk);
         claim = 1'b1;
         drv.irdy = 1'b0;
         drv.frame = (k == w.size() - 1);
         drv.cbe = ~w[k].be;
         drv.ad = w[k].data;
         drv.adOe = cmd[0];
         do @(posedge clk); while (!compl);
         capQ.push_back({adW, ~cbeW_n});
      end
      @(negedge clk);
      drv.irdy = 1'b1;
      {drv.frameOe, drv.adOe, drv.cbeOe, claim} = 4'h0;
      @(negedge clk);
      drv.irdyOe = 1'b0;
      mBusy = 1'b0;
   endtask : run
endmodule : padp_peer

// File: sim/tb_top.sv
// tb_top: self-checking bench for the pci address/data port
// assumes one 50 MHz clock and the peer agent standing for the bus
`timescale 1ns/1ps
module tb_top
   import padp_pkg::*;
;
   logic clk, reset_n, mstReqValid, gntOk, tgtWrite, tgtRdy, stall;
   padp_req_t mstReq; // request to the master engine
   padp_word_t mstWr, mstRd, tgtWr, expD[$], expP[$];
   logic [AD_W+CBE_W-1:0] expA[$]; // expected address phases
   logic mstRdValid, mstWrTake, mstDone, mstBusy, tgtSel, tgtTake;
   logic tgtWrValid, parBad, adOe, cbeOe, parOut, parOe, parW, parFl;
   logic frameOut_n, frameOe, irdyOut_n, irdyOe, trdyOut_n, trdyOe;
   logic frameW_n, irdyW_n, trdyW_n, pCompl, selP, claimEd, parFlip;
   logic [AD_W-1:0] tgtRdData, adOut, adW, adFl, rdW[0:15];
   logic [CBE_W-1:0] cbeOut_n, cbeW_n, cbeFl;
   logic [CBE_W-1:0] cmds[6] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb};
   logic [2:0] oeP, outP; // port control enables and levels last cycle
   padp_drv_t pd; // peer drivers
   int n_fail = 0, check_count = 0, cyc = 0, tn = 0, rdIdx = 0;
   int nTake = 0, nBad = 0, expBad = 0; // read words taken, parity reports

   // released data lines wander; control lines have pull-ups
   assign adW = adOe ? adOut : (pd.adOe ? pd.ad : adFl);
   assign cbeW_n = cbeOe ? cbeOut_n : (pd.cbeOe ? pd.cbe : cbeFl);
   // parFlip corrupts the peer's parity to provoke the port's check
   assign parW = parOe ? parOut : (pd.parOe ? pd.par ^ parFlip : parFl);
   assign frameW_n = frameOe ? frameOut_n : (pd.frameOe ? pd.frame : 1'b1);
   assign irdyW_n = irdyOe ? irdyOut_n : (pd.irdyOe ? pd.irdy : 1'b1);
   assign trdyW_n = trdyOe ? trdyOut_n : (pd.trdyOe ? pd.trdy : 1'b1);

   padp_port DUT (.clk(clk), .reset_n(reset_n), .mstReq(mstReq),
      .mstReqValid(mstReqValid), .gntOk(gntOk), .mstWr(mstWr),
      .mstRd(mstRd), .mstRdValid(mstRdValid), .mstWrTake(mstWrTake),
      .mstDone(mstDone), .mstBusy(mstBusy), .tgtSel(tgtSel),
      .tgtWrite(tgtWrite), .tgtRdData(tgtRdData), .tgtRdy(tgtRdy),
      .tgtTake(tgtTake), .tgtWr(tgtWr), .tgtWrValid(tgtWrValid),
      .parBad(parBad), .adIn(adW), .adOut(adOut), .adOe(adOe),
      .cbeIn_n(cbeW_n), .cbeOut_n(cbeOut_n), .cbeOe(cbeOe),
      .parIn(parW), .parOut(parOut), .parOe(parOe),
      .frameIn_n(frameW_n), .frameOut_n(frameOut_n), .frameOe(frameOe),
      .irdyIn_n(irdyW_n), .irdyOut_n(irdyOut_n), .irdyOe(irdyOe),
      .trdyIn_n(trdyW_n), .trdyOut_n(trdyOut_n), .trdyOe(trdyOe));
   padp_peer pe (.clk(clk), .reset_n(reset_n), .stall(stall), .adW(adW),
      .cbeW_n(cbeW_n), .parW(parW), .frameW_n(frameW_n),
      .irdyW_n(irdyW_n), .trdyW_n(trdyW_n), .drv(pd), .claim(tgtSel));

   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // compare what the peer saw against the model, then report
   task automatic drain();
      repeat (4) @(negedge clk);
      while (pe.addrQ.size() > 0)
         check(pe.addrQ.pop_front(), expA.pop_front());
      while (pe.capQ.size() > 0)
         check(pe.capQ.pop_front(), expP.pop_front());
      check(expA.size() + expP.size() + expD.size(), 0);
      check(pe.parErr, 0);
      check(nBad, expBad);
      {nBad, expBad} = 0;
      $display("test %0d done, checks %0d, fails %0d", tn, check_count,
         n_fail);
      tn++;
   endtask : drain
   // port as master; len zero still runs a single data phase
   task automatic mst(input logic [CBE_W-1:0] cmd, input int n);
      padp_word_t w[$], x;
      logic [AD_W-1:0] a;
      int k, t;
      a = $urandom;
      for (k = 0; k < ((n == 0) ? 1 : n); k++) begin
         w.push_back({$urandom, 4'($urandom)});
         x = {w[k].data, cmd[0] ? w[k].be : w[0].be};
         expP.push_back(x);
         if (!cmd[0]) begin
            expD.push_back(x);
            pe.rdQ.push_back(w[k].data);
         end
      end
      expA.push_back({(cmd[3:1] == 3'h1) ? a : {a[31:2], 2'h0}, cmd});
      mstReq = '{cmd: cmd, addr: a, len: 4'(n)};
      mstWr = w[0];
      mstReqValid = 1'b1;
      {k, t} = 0;
      do begin
         @(negedge clk);
         t++;
         gntOk = gntOk | 1'($urandom); // grant lands at a random cycle
         if (mstBusy) mstReqValid = 1'b0;
         if (mstWrTake && k < w.size() - 1) mstWr = w[++k];
      end while (!mstDone && t < 300);
      gntOk = 1'b0;
      check(t < 300, 1);
      drain();
   endtask : mst
   // port as target; the peer opens the transaction
   task automatic tgt(input logic [CBE_W-1:0] cmd, input int len);
      padp_word_t w[$];
      for (int k = 0; k < len; k++) begin
         w.push_back({$urandom, 4'($urandom)});
         rdW[k] = $urandom;
         expP.push_back(cmd[0] ? w[k] : {rdW[k], w[k].be});
         if (cmd[0]) expD.push_back(w[k]);
      end
      {rdIdx, nTake} = 0;
      tgtWrite = cmd[0];
      pe.run(cmd, $urandom, w);
      check(nTake, cmd[0] ? 0 : len);
      drain();
   endtask : tgt
   ////////////////////////////////////////////////////////////////
   // random readiness each cycle; next read word ready after each claim or completed phase
   always @(negedge clk) begin
      tgtRdy = 1'($urandom);
      stall = 1'($urandom);
      if (pCompl || claimEd) rdIdx++;
      tgtRdData = rdW[rdIdx];
   end
   // cycle ceiling, far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         close_out();
      end
   end
   // bus-wide watch: ownership, release order, received words
   always @(posedge clk) begin
      if (reset_n) begin
         check({adOe & pd.adOe, cbeOe & pd.cbeOe, parOe & pd.parOe,
            frameOe & pd.frameOe, irdyOe & pd.irdyOe,
            trdyOe & pd.trdyOe}, 0);
         check(oeP & ~{frameOe, irdyOe, trdyOe} & ~outP, 0);
         if (parBad) nBad++;
         if (tgtTake) nTake++;
         if (mstRdValid) check(mstRd, expD.pop_front());
         if (tgtWrValid) check(tgtWr, expD.pop_front());
      end
      oeP <= {frameOe, irdyOe, trdyOe};
      outP <= {frameOut_n, irdyOut_n, trdyOut_n};
      pCompl <= !irdyW_n && !trdyW_n;
      claimEd <= tgtSel && !selP;
      selP <= tgtSel;
      {adFl, cbeFl, parFl} <= ~{adW, cbeW_n, parW};
   end
   // reset, then every command both ways, boundary lengths included
   initial begin
      {clk, reset_n, mstReqValid, gntOk, tgtWrite, tgtRdy, stall} = 7'h0;
      {mstReq, mstWr, tgtRdData} = '0;
      {adFl, cbeFl, parFl, oeP, outP, pCompl, selP, claimEd, parFlip} = '0;
      foreach (rdW[i]) rdW[i] = '0;
      void'($urandom(32'h9f3049ec));
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      foreach (cmds[i]) mst(cmds[i], $urandom_range(0, 4));
      mst(4'h7, 15);
      mst(4'h6, 15);
      // bad read parity: one report for each completed phase
      parFlip = 1'b1;
      expBad = 3;
      mst(4'h6, 3);
      parFlip = 1'b0;
      foreach (cmds[i]) tgt(cmds[i], 1 + $urandom_range(0, 7));
      close_out();
   end
endmodule : tb_top
